// ===== dfb_pkg.sv
package dfb_pkg;

    // Common timing tick: 100 ms at a 250 MHz core clock
    localparam int CLK_MHZ = 250;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
    localparam int TICK_CW = 25;
    localparam int TIMER_W = 16;
    localparam int DATA_W = 12;

    // Dwell in tenths of a second: 0.1 s .. 60 s, factory 1 s
    localparam logic [9:0] DWELL_MIN = 10'h001;
    localparam logic [9:0] DWELL_MAX = 10'h258;
    localparam logic [9:0] DWELL_FACTORY = 10'h00a;

    // Auto restart: 1..5 tries, 1..600 s apart
    localparam logic [2:0] TRIES_MIN = 3'h1;
    localparam logic [2:0] TRIES_MAX = 3'h5;
    localparam logic [9:0] AUTO_DELAY_MIN = 10'h001;
    localparam logic [9:0] AUTO_DELAY_MAX = 10'h258;
    localparam logic [15:0] TICKS_PER_SEC = 16'h000a;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEQ_WAIT = 3'b001,
        ST_ACCEL = 3'b010,
        ST_RUN = 3'b011,
        ST_DECEL = 3'b100,
        ST_DWELL = 3'b101,
        ST_FAULT = 3'b110
    } dfb_state_e;

    typedef enum logic [2:0] {
        DM_OFF = 3'b000,
        DM_RUN = 3'b001,
        DM_RAMP_DOWN = 3'b010,
        DM_FAST_STOP = 3'b011,
        DM_DWELL = 3'b100
    } dfb_mode_e;

    typedef enum logic [1:0] {
        STOP_RAMP = 2'b00,
        STOP_FAST = 2'b01,
        STOP_COAST = 2'b10
    } dfb_stop_e;

    typedef enum logic [1:0] {
        LOF_FAULT = 2'b00,
        LOF_PRESET = 2'b01,
        LOF_IGNORE = 2'b10
    } dfb_lof_e;

    typedef enum logic [1:0] {
        LO_NONE = 2'b00,
        LO_SHUTDOWN_DONE = 2'b01,
        LO_ERR_LIMIT = 2'b10,
        LO_FB_HIGH = 2'b11
    } dfb_losel_e;

    typedef enum logic [3:0] {
        FLT_NONE = 4'h0,
        FLT_SEQ_TIMEOUT = 4'h1,
        FLT_PROC_TIMEOUT = 4'h2,
        FLT_INTERNAL = 4'h3,
        FLT_DYN_BRAKE = 4'h4,
        FLT_OVERVOLT = 4'h5,
        FLT_OUT_PHASE = 4'h6,
        FLT_IN_PHASE = 4'h7,
        FLT_LOSS_FOLLOWER = 4'h8,
        FLT_OVERTEMP = 4'h9
    } dfb_fault_e;

endpackage

// ===== dfb_plant_model.sv
`timescale 1ns/1ns
`default_nettype none
module dfb_plant_model (
    input wire logic core_clk,
    input wire logic runOutputCmd,
    input wire logic [2:0] driveMode,
    input wire logic [1:0] blk,
    output logic seqInput,
    output logic procInput,
    output logic lowSpeedReached
);
    logic [3:0] spd = 4'h0;
    logic [1:0] dly = 2'h0;
    // Contactor auxiliary closes two cycles after the coil, opens one cycle after it
    always @(posedge core_clk) begin
        dly <= runOutputCmd ? {dly[0], 1'b1} : 2'h0;
        if (driveMode == 3'h1 && spd < 4'h8)
            spd <= spd + 4'h1;
        else if (driveMode == 3'h3 && spd > 4'h1)
            spd <= spd - 4'h2;
        else if (driveMode != 3'h1 && driveMode != 3'h4 && spd != 4'h0)
            spd <= spd - 4'h1;
    end
    // Blocking bits let a scenario hold back either plant confirmation
    assign seqInput = dly[1] & ~blk[0];
    assign procInput = spd > 4'h3 && !blk[1];
    assign lowSpeedReached = spd == 4'h0;
endmodule // dfb_plant_model
`default_nettype wire

// ===== dfb_sequencer.sv
// What this block does
// R1: After shutdown deceleration, hold low dwell speed for the dwell time, then stop.
// R2: Dwell time 0.1 to 60 s; factory value 1 s.
// R3: On dwell expiry, assigned logic output shows shutdown complete.
// R4: Up to three parameter sets; apply the selected one.
// R5: With two or three motors, user wires motor select inputs.
// R6: Process regulator allowed only under two-wire control.
// R7: Output flags setpoint-to-feedback error above user limit.
// R8: Alarm outputs for feedback above high level and below low level.
// R9: After bypass, wait the restart delay before restarting.
// R10: Run command plus expired delay energizes the isolation contactor output.
// R11: Sequence input not high in time gives sequence time-out fault, no start.
// R12: Process input not high in time after ramp start faults and stops.
// R13: Internal protection faults always turn output off and coast.
// R14: Programmable faults share one stop type: ramp, fast or coast.
// R15: Auto restart only with two-wire: 1-5 tries, 1-600 s apart.
// R16: Reset input clears resettable faults; latching faults need power cycle.
// R17: On input power loss, coast or ramp as configured.
// R18: Input phase failure detection can be switched off.
// R19: Output phase loss detection can be switched off.
// R20: Live-zero reference below 3 mA: fault, preset speed or ignore.
// R21: Dynamic brake check raises fault on short or overrating.
// R22: Two-wire run is a held level; three-wire run acts on edges.
// R23: All delays count a common fixed-period tick.
`timescale 1ns/1ns
`default_nettype none
module dfb_sequencer #(
    parameter int TICK_CYCLES = dfb_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic runCmd,
    input wire logic stopPushN,
    input wire logic twoWireMode,
    input wire logic piEnable,
    input wire logic shutdownEn,
    input wire logic [9:0] dwellTime,
    input wire logic dwellFactory,
    input wire logic lowSpeedReached,
    input wire logic [1:0] motorCount,
    input wire logic [1:0] motorSelIn,
    input wire logic [11:0] setpoint,
    input wire logic [11:0] feedback,
    input wire logic [11:0] regulatorErrorLimit,
    input wire logic [11:0] highLevel,
    input wire logic [11:0] lowLevel,
    input wire logic bypassActive,
    input wire logic [15:0] restartDelayTime,
    input wire logic seqInput,
    input wire logic [15:0] seqTimeout,
    input wire logic procCheckEn,
    input wire logic procInput,
    input wire logic [15:0] procTimeout,
    input wire logic [1:0] stopType,
    input wire logic autoRestartEn,
    input wire logic [2:0] autoTries,
    input wire logic [9:0] autoDelay,
    input wire logic faultReset,
    input wire logic internalFault,
    input wire logic overVoltFault,
    input wire logic overTempFault,
    input wire logic powerLoss,
    input wire logic powerLossRamp,
    input wire logic inPhaseFail,
    input wire logic inPhaseDetOff,
    input wire logic outPhaseLoss,
    input wire logic outPhaseDetOff,
    input wire logic refBelowLiveZero,
    input wire logic [1:0] lossFollowerMode,
    input wire logic dbFitted,
    input wire logic dbCheckEn,
    input wire logic dbFaultSense,
    input wire logic [1:0] firstLoSelect,
    output logic runOutputCmd,
    output logic [2:0] driveMode,
    output logic shutdownDone,
    output logic firstLogicOutput,
    output logic [1:0] activeSet,
    output logic piActive,
    output logic errAlarm,
    output logic fbHighAlarm,
    output logic fbLowAlarm,
    output logic presetSpeedReq,
    output logic faultActive,
    output logic [3:0] faultCode,
    output logic faultLatched
);
    typedef struct packed {
        dfb_pkg::dfb_state_e state;
        logic [dfb_pkg::TIMER_W-1:0] timer;
        logic waitRoc;
        logic run3w;
        logic prevRun;
        logic [2:0] tries;
        logic latched;
        dfb_pkg::dfb_stop_e faultStop;
        dfb_pkg::dfb_fault_e code;
        logic runOut;
        dfb_pkg::dfb_mode_e mode;
        logic sdDone;
        logic firstLo;
        logic [1:0] set;
        logic piOn;
        logic errA;
        logic hiA;
        logic loA;
        logic preset;
        logic faultOn;
    } dfb_seq_s;

    dfb_seq_s q;
    dfb_seq_s d;
    logic tick;
    logic runReq;
    logic timerDone;
    logic piOk;
    logic [11:0] errMag;
    logic [9:0] dwellTicks;
    logic [9:0] delaySec;
    logic [2:0] triesMax;
    logic latchNew;
    logic coastNew;
    logic progNew;
    logic anyNew;
    dfb_pkg::dfb_fault_e newCode;

    dfb_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .tick(tick)
    );

    always_comb begin
        // Held level under two-wire, latched from the rising edge under three-wire
        runReq = twoWireMode ? runCmd : q.run3w; // R22
        timerDone = (q.timer == '0);
        piOk = piEnable && twoWireMode; // R6
        errMag = (setpoint >= feedback) ? setpoint - feedback : feedback - setpoint;
        if (dwellFactory) begin // R2
            dwellTicks = dfb_pkg::DWELL_FACTORY;
        end else if (dwellTime < dfb_pkg::DWELL_MIN) begin
            dwellTicks = dfb_pkg::DWELL_MIN;
        end else if (dwellTime > dfb_pkg::DWELL_MAX) begin
            dwellTicks = dfb_pkg::DWELL_MAX;
        end else begin
            dwellTicks = dwellTime;
        end
        if (autoDelay < dfb_pkg::AUTO_DELAY_MIN) begin // R15
            delaySec = dfb_pkg::AUTO_DELAY_MIN;
        end else if (autoDelay > dfb_pkg::AUTO_DELAY_MAX) begin
            delaySec = dfb_pkg::AUTO_DELAY_MAX;
        end else begin
            delaySec = autoDelay;
        end
        if (autoTries < dfb_pkg::TRIES_MIN) begin
            triesMax = dfb_pkg::TRIES_MIN;
        end else if (autoTries > dfb_pkg::TRIES_MAX) begin
            triesMax = dfb_pkg::TRIES_MAX;
        end else begin
            triesMax = autoTries;
        end

        latchNew = internalFault || (dbFitted && dbCheckEn && dbFaultSense); // R13 R21
        coastNew = overVoltFault || (outPhaseLoss && !outPhaseDetOff); // R19
        progNew = overTempFault || (inPhaseFail && !inPhaseDetOff) // R18
            || (refBelowLiveZero && lossFollowerMode == dfb_pkg::LOF_FAULT); // R20
        if (internalFault) begin
            newCode = dfb_pkg::FLT_INTERNAL;
        end else if (latchNew) begin
            newCode = dfb_pkg::FLT_DYN_BRAKE;
        end else if (overVoltFault) begin
            newCode = dfb_pkg::FLT_OVERVOLT;
        end else if (coastNew) begin
            newCode = dfb_pkg::FLT_OUT_PHASE;
        end else if (overTempFault) begin
            newCode = dfb_pkg::FLT_OVERTEMP;
        end else if (inPhaseFail && !inPhaseDetOff) begin
            newCode = dfb_pkg::FLT_IN_PHASE;
        end else begin
            newCode = dfb_pkg::FLT_LOSS_FOLLOWER;
        end

        d = q;
        d.prevRun = runCmd;
        if (!stopPushN) begin // R22
            d.run3w = 1'b0;
        end else if (runCmd && !q.prevRun) begin
            d.run3w = 1'b1;
        end
        if (tick && !timerDone) begin // R23
            d.timer = q.timer - 1'b1;
        end

        case (q.state)
            dfb_pkg::ST_IDLE: begin
                d.runOut = 1'b0;
                d.mode = dfb_pkg::DM_OFF;
                if (bypassActive) begin // R9
                    d.waitRoc = 1'b1;
                    d.timer = restartDelayTime;
                end else if (q.waitRoc && timerDone) begin
                    d.waitRoc = 1'b0;
                end else if (runReq && !q.waitRoc && !powerLoss) begin // R10
                    d.state = dfb_pkg::ST_SEQ_WAIT;
                    d.runOut = 1'b1;
                    d.sdDone = 1'b0;
                    d.timer = seqTimeout;
                end
            end
            dfb_pkg::ST_SEQ_WAIT: begin
                if (!runReq) begin
                    d.state = dfb_pkg::ST_IDLE;
                    d.runOut = 1'b0;
                end else if (seqInput) begin
                    d.state = dfb_pkg::ST_ACCEL;
                    d.mode = dfb_pkg::DM_RUN;
                    d.timer = procTimeout;
                end else if (timerDone) begin // R11
                    d.state = dfb_pkg::ST_FAULT;
                    d.code = dfb_pkg::FLT_SEQ_TIMEOUT;
                    d.faultStop = dfb_pkg::STOP_COAST;
                    d.runOut = 1'b0;
                end
            end
            dfb_pkg::ST_ACCEL: begin
                if (!runReq) begin
                    d.state = dfb_pkg::ST_DECEL;
                    d.mode = dfb_pkg::DM_RAMP_DOWN;
                end else if (!procCheckEn || procInput) begin
                    d.state = dfb_pkg::ST_RUN;
                    d.tries = '0;
                end else if (timerDone) begin // R12
                    d.state = dfb_pkg::ST_FAULT;
                    d.code = dfb_pkg::FLT_PROC_TIMEOUT;
                    d.faultStop = dfb_pkg::dfb_stop_e'(stopType); // R14
                end
            end
            dfb_pkg::ST_RUN: begin
                if (!runReq) begin
                    d.state = dfb_pkg::ST_DECEL;
                    d.mode = dfb_pkg::DM_RAMP_DOWN;
                end
            end
            dfb_pkg::ST_DECEL: begin
                if (lowSpeedReached && shutdownEn) begin // R1
                    d.state = dfb_pkg::ST_DWELL;
                    d.mode = dfb_pkg::DM_DWELL;
                    d.timer = dfb_pkg::TIMER_W'(dwellTicks);
                end else if (lowSpeedReached) begin
                    d.state = dfb_pkg::ST_IDLE;
                    d.mode = dfb_pkg::DM_OFF;
                    d.runOut = 1'b0;
                end
            end
            dfb_pkg::ST_DWELL: begin
                if (timerDone) begin // R1
                    d.state = dfb_pkg::ST_IDLE;
                    d.mode = dfb_pkg::DM_OFF;
                    d.runOut = 1'b0;
                    d.sdDone = 1'b1; // R3
                end
            end
            dfb_pkg::ST_FAULT: begin
                d.runOut = 1'b0;
                if (q.latched || q.faultStop == dfb_pkg::STOP_COAST || lowSpeedReached) begin
                    d.mode = dfb_pkg::DM_OFF; // R13
                end else if (q.faultStop == dfb_pkg::STOP_FAST) begin
                    d.mode = dfb_pkg::DM_FAST_STOP;
                end else begin
                    d.mode = dfb_pkg::DM_RAMP_DOWN;
                end
                // Clearing only frees the sequencer; a held run then starts afresh
                if (!q.latched && faultReset) begin // R16
                    d.state = dfb_pkg::ST_IDLE;
                    d.code = dfb_pkg::FLT_NONE;
                    d.tries = '0;
                end else if (!q.latched && autoRestartEn && twoWireMode // R15
                             && q.tries < triesMax && timerDone) begin
                    d.state = dfb_pkg::ST_IDLE;
                    d.code = dfb_pkg::FLT_NONE;
                    d.tries = q.tries + 1'b1;
                end
            end
            default: begin
                d.state = dfb_pkg::ST_IDLE;
            end
        endcase

        // Power loss is not a fault: it only ends the run in the chosen manner
        if (powerLoss && q.state != dfb_pkg::ST_IDLE && q.state != dfb_pkg::ST_FAULT) begin // R17
            if (powerLossRamp) begin
                if (q.state != dfb_pkg::ST_DECEL && q.state != dfb_pkg::ST_DWELL) begin
                    d.state = dfb_pkg::ST_DECEL;
                    d.mode = dfb_pkg::DM_RAMP_DOWN;
                end
            end else begin
                d.state = dfb_pkg::ST_IDLE;
                d.mode = dfb_pkg::DM_OFF;
                d.runOut = 1'b0;
            end
        end

        anyNew = latchNew || coastNew || progNew;
        // First fault holds the code; a latching one overrides any resettable one
        if ((anyNew && q.state != dfb_pkg::ST_FAULT) || (latchNew && !q.latched)) begin
            d.state = dfb_pkg::ST_FAULT;
            d.code = newCode;
            d.runOut = 1'b0;
            d.latched = latchNew; // R16
            d.timer = TICKS_FOR(delaySec);
            if (latchNew || coastNew) begin // R13
                d.faultStop = dfb_pkg::STOP_COAST;
                d.mode = dfb_pkg::DM_OFF;
            end else begin
                d.faultStop = dfb_pkg::dfb_stop_e'(stopType); // R14
            end
        end else if (d.state == dfb_pkg::ST_FAULT && q.state != dfb_pkg::ST_FAULT) begin
            d.timer = TICKS_FOR(delaySec); // R15
        end

        // Clamp a selection beyond the configured motor count to the last set
        if (motorCount == 2'h0 || motorSelIn >= motorCount) begin // R4
            d.set = (motorCount == 2'h0) ? 2'h0 : motorCount - 2'h1;
        end else begin
            d.set = motorSelIn;
        end

        d.piOn = piOk;
        d.errA = piOk && (errMag > regulatorErrorLimit); // R7
        d.hiA = piOk && (feedback > highLevel); // R8
        d.loA = piOk && (feedback < lowLevel); // R8
        d.preset = refBelowLiveZero && lossFollowerMode == dfb_pkg::LOF_PRESET; // R20
        d.faultOn = (d.state == dfb_pkg::ST_FAULT);

        case (firstLoSelect)
            dfb_pkg::LO_SHUTDOWN_DONE: d.firstLo = d.sdDone; // R3
            dfb_pkg::LO_ERR_LIMIT: d.firstLo = d.errA;
            dfb_pkg::LO_FB_HIGH: d.firstLo = d.hiA;
            default: d.firstLo = 1'b0;
        endcase
    end

    function automatic logic [dfb_pkg::TIMER_W-1:0] TICKS_FOR(input logic [9:0] sec);
        TICKS_FOR = dfb_pkg::TIMER_W'(dfb_pkg::TIMER_W'(sec) * dfb_pkg::TICKS_PER_SEC);
    endfunction

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign runOutputCmd = q.runOut;
    assign driveMode = q.mode;
    assign shutdownDone = q.sdDone;
    assign firstLogicOutput = q.firstLo;
    assign activeSet = q.set;
    assign piActive = q.piOn;
    assign errAlarm = q.errA;
    assign fbHighAlarm = q.hiA;
    assign fbLowAlarm = q.loA;
    assign presetSpeedReq = q.preset;
    assign faultActive = q.faultOn;
    assign faultCode = q.code;
    assign faultLatched = q.latched;

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    contactor_gate_a: assert property ($rose(runOutputCmd) |-> !$past(q.waitRoc) && !$past(bypassActive)) // R10
        else $error("Contactor energized during restart delay");
    dwell_entry_a: assert property (clkEn && q.state == dfb_pkg::ST_DECEL && lowSpeedReached // R1
        && shutdownEn && !anyNew && !powerLoss |=> driveMode == dfb_pkg::DM_DWELL)
        else $error("Dwell not entered after shutdown decel");
    seq_timeout_a: assert property (clkEn && q.state == dfb_pkg::ST_SEQ_WAIT && timerDone // R11
        && runReq && !seqInput && !powerLoss |=> faultActive && !runOutputCmd)
        else $error("Sequence time-out did not fault");
    latched_coast_a: assert property (faultLatched |-> driveMode == dfb_pkg::DM_OFF && faultActive) // R13
        else $error("Latching fault without coast");
    pi_gate_a: assert property (clkEn && !twoWireMode |=> !piActive ##0 !errAlarm && !fbHighAlarm) // R6
        else $error("Regulator active outside two-wire control");
    fb_high_a: assert property (clkEn && piOk && feedback > highLevel |=> fbHighAlarm) // R8
        else $error("High feedback alarm missing");
    tries_bound_a: assert property (q.tries <= dfb_pkg::TRIES_MAX) // R15
        else $error("Restart attempts beyond limit");
    reset_clear_a: assert property (clkEn && faultActive && !faultLatched && faultReset // R16
        && !anyNew |=> !faultActive ##1 faultCode == dfb_pkg::FLT_NONE || faultActive)
        else $error("Fault reset ignored");
    set_range_a: assert property (motorCount != 2'h0 |=> activeSet < $past(motorCount) || !$past(clkEn)) // R4
        else $error("Parameter set beyond motor count");
endmodule // dfb_sequencer
`default_nettype wire

// ===== dfb_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none
module dfb_tick_gen #(
    parameter int TICK_CYCLES = dfb_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    output logic tick
);
    typedef struct packed {
        logic [dfb_pkg::TICK_CW-1:0] count;
        logic tick;
    } dfb_tick_s;

    localparam logic [dfb_pkg::TICK_CW-1:0] LAST = dfb_pkg::TICK_CW'(TICK_CYCLES - 1);

    dfb_tick_s q;
    dfb_tick_s d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.count == LAST) begin // R23
            d.count = '0;
            d.tick = 1'b1;
        end else begin
            d.count = q.count + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign tick = q.tick;

    tick_single_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R23
        clkEn && q.tick |=> !q.tick || LAST == '0)
        else $error("Tick lasted more than one enabled cycle");
endmodule // dfb_tick_gen
`default_nettype wire

// ===== tb_drive_fault_bypass_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_drive_fault_bypass_sequencer;
    logic core_clk = 1'b0, sys_rst = 1'b1, runCmd = 1'b0, stopPushN = 1'b1;
    logic twoWireMode = 1'b1, piEnable = 1'b0, shutdownEn = 1'b1, dwellFactory = 1'b0;
    logic [9:0] dwellTime = 10'h001, autoDelay = 10'h001;
    logic [1:0] motorCount = 2'h1, motorSelIn = 2'h0, stopType = 2'h0, lossFollowerMode = 2'h0;
    logic [1:0] firstLoSelect = 2'h1, blk = 2'h0, detOff = 2'h0;
    logic [11:0] setpoint = 12'h400, feedback = 12'h3c0, regulatorErrorLimit = 12'h100;
    logic [11:0] highLevel = 12'h450, lowLevel = 12'h100;
    logic bypassActive = 1'b0, faultReset = 1'b0, powerLoss = 1'b0, powerLossRamp = 1'b0;
    logic clkEn = 1'b1, autoRestartEn = 1'b0;
    logic [15:0] restartDelayTime = 16'h0000, seqTimeout = 16'h0003, procTimeout = 16'h0008;
    logic [6:0] flt = 7'h00;
    logic seqInput, procInput, lowSpeedReached, runOutputCmd, shutdownDone, firstLogicOutput;
    logic piActive, errAlarm, fbHighAlarm, fbLowAlarm, presetSpeedReq, faultActive, faultLatched;
    logic [2:0] driveMode;
    logic [1:0] activeSet;
    logic [3:0] faultCode;
    int miscompares = 0, n_tests = 0, cycles = 0, k, n;
    logic [6:0] fm [10] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h04, 7'h08, 7'h10};
    logic [3:0] fc [10] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h4, 4'h9, 4'h0, 4'h0, 4'h0};
    logic [3:0] fo [10] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h1, 4'h4};
    logic [2:0] mv [5] = '{3'h2, 3'h3, 3'h0, 3'h2, 3'h0};
    logic [11:0] fbv [3] = '{12'h480, 12'h0a0, 12'h3c0};
    logic [3:0] alv [3] = '{4'h5, 4'hb, 4'h0};
    dfb_sequencer #(.TICK_CYCLES(4)) u_dfb_sequencer (
        .core_clk, .sys_rst, .clkEn, .runCmd, .stopPushN, .twoWireMode, .piEnable,
        .shutdownEn, .dwellTime, .dwellFactory, .lowSpeedReached, .motorCount,
        .motorSelIn, .setpoint, .feedback, .regulatorErrorLimit, .highLevel, .lowLevel,
        .bypassActive, .restartDelayTime, .seqInput, .seqTimeout, .procCheckEn(1'b1),
        .procInput, .procTimeout, .stopType, .autoRestartEn, .autoTries(3'h1),
        .autoDelay, .faultReset, .internalFault(flt[0]), .overVoltFault(flt[1]),
        .overTempFault(flt[6]), .powerLoss, .powerLossRamp, .inPhaseFail(flt[3]),
        .inPhaseDetOff(detOff[0]), .outPhaseLoss(flt[2]), .outPhaseDetOff(detOff[1]),
        .refBelowLiveZero(flt[4]), .lossFollowerMode, .dbFitted(1'b1), .dbCheckEn(1'b1),
        .dbFaultSense(flt[5]), .firstLoSelect, .runOutputCmd, .driveMode, .shutdownDone,
        .firstLogicOutput, .activeSet, .piActive, .errAlarm, .fbHighAlarm, .fbLowAlarm,
        .presetSpeedReq, .faultActive, .faultCode, .faultLatched);
    dfb_plant_model u_dfb_plant_model (.core_clk, .runOutputCmd, .driveMode, .blk,
        .seqInput, .procInput, .lowSpeedReached);
    always #2 core_clk = ~core_clk;
    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic waitMode(input logic [2:0] m, input int lim);
        for (int i = 0; i < lim && driveMode !== m; i++)
            cyc(1);
    endtask
    task automatic start();
        runCmd = 1'b1;
        waitMode(3'h1, 20);
        chk({runOutputCmd, driveMode}, 16'h0009);
    endtask
    task automatic stopAll();
        runCmd = 1'b0;
        flt = 7'h00;
        powerLoss = 1'b0;
        blk = 2'h0;
        waitMode(3'h0, 80);
        faultReset = 1'b1;
        cyc(1);
        faultReset = 1'b0;
        cyc(2);
        chk({faultActive, runOutputCmd, driveMode}, 16'h0000);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Whole run needs well under 1000 cycles; the ceiling leaves ample margin
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        cyc(20);
        sys_rst = 1'b0;
        cyc(1);
        chk({runOutputCmd, driveMode, faultActive, faultCode}, 16'h0000);
        for (k = 0; k < 4; k++) begin
            motorCount = k == 3 ? 2'h1 : 2'h3;
            motorSelIn = k == 3 ? 2'h2 : k[1:0];
            cyc(2);
            chk(activeSet, k == 3 ? 0 : k);
        end
        // Frozen clock enable must keep the old set although the motor count moved
        clkEn = 1'b0;
        motorCount = 2'h3;
        cyc(3);
        chk(activeSet, 0);
        clkEn = 1'b1;
        piEnable = 1'b1;
        firstLoSelect = 2'h2;
        for (k = 0; k < 3; k++) begin
            feedback = fbv[k];
            firstLoSelect = k == 0 ? 2'h3 : 2'h2;
            cyc(3);
            chk({errAlarm, fbHighAlarm, fbLowAlarm, firstLogicOutput}, alv[k]);
        end
        twoWireMode = 1'b0;
        cyc(3);
        chk(piActive, 0);
        twoWireMode = 1'b1;
        piEnable = 1'b0;
        restartDelayTime = 16'h0004;
        bypassActive = 1'b1;
        runCmd = 1'b1;
        cyc(6);
        chk(runOutputCmd, 0);
        bypassActive = 1'b0;
        cyc(10);
        chk(runOutputCmd, 0);
        for (k = 0; k < 20 && runOutputCmd !== 1'b1; k++)
            cyc(1);
        chk(runOutputCmd, 1);
        restartDelayTime = 16'h0000;
        stopAll();
        for (k = 0; k < 2; k++) begin
            blk = k == 0 ? 2'h1 : 2'h2;
            runCmd = 1'b1;
            cyc(8);
            chk({faultActive, runOutputCmd}, 1);
            for (n = 0; n < 60 && faultActive !== 1'b1; n++)
                cyc(1);
            chk(faultCode, k + 1);
            // Stop mode follows one cycle after the fault is entered
            cyc(1);
            chk(driveMode, k == 0 ? 0 : 2);
            stopAll();
        end
        for (k = 0; k < 5; k++) begin
            stopType = k < 3 ? k[1:0] : 2'h0;
            powerLossRamp = k == 3;
            start();
            cyc(10);
            if (k < 3)
                flt[6] = 1'b1;
            else
                powerLoss = 1'b1;
            cyc(3);
            chk(driveMode, mv[k]);
            stopAll();
        end
        firstLoSelect = 2'h1;
        dwellTime = 10'h003;
        for (k = 0; k < 2; k++) begin
            dwellFactory = k == 0;
            n = k == 0 ? 10 : 3;
            start();
            cyc(10);
            runCmd = 1'b0;
            cyc(2);
            chk(driveMode, 2);
            waitMode(3'h4, 30);
            cyc(n * 4 - 6);
            chk({driveMode, shutdownDone}, 16'h0008);
            waitMode(3'h0, 16);
            chk({runOutputCmd, driveMode, shutdownDone, firstLogicOutput}, 16'h0003);
        end
        for (k = 0; k < 10; k++) begin
            detOff = fo[k][1:0];
            lossFollowerMode = fo[k][3:2];
            flt = fm[k];
            cyc(3);
            chk({presetSpeedReq, faultCode, driveMode}, {k == 9, fc[k], 3'h0});
            flt = 7'h00;
            faultReset = 1'b1;
            cyc(2);
            faultReset = 1'b0;
            cyc(1);
            chk({faultLatched, faultCode}, fc[k] inside {4'h3, 4'h4} ? {1'b1, fc[k]} : 5'h00);
            sys_rst = 1'b1;
            cyc(1);
            sys_rst = 1'b0;
            cyc(1);
        end
        autoRestartEn = 1'b1;
        for (k = 0; k < 2; k++) begin
            flt = 7'h02;
            cyc(30);
            chk(faultActive, 1);
            flt = 7'h00;
            cyc(16);
            chk(faultActive, k);
        end
        stopAll();
        autoRestartEn = 1'b0;
        twoWireMode = 1'b0;
        runCmd = 1'b1;
        cyc(1);
        runCmd = 1'b0;
        waitMode(3'h1, 20);
        chk(driveMode, 1);
        stopPushN = 1'b0;
        cyc(1);
        stopPushN = 1'b1;
        waitMode(3'h0, 60);
        chk({runOutputCmd, driveMode}, 0);
        final_report();
    end
endmodule // tb_drive_fault_bypass_sequencer
`default_nettype wire
